// >>> src/rsc_top.sv
/*
 Reset source controller: merges six reset sources, runs the fuse,
 start-up and CRC phases, keeps cause flags and the soft reset trigger,
 all reached over AXI4-Lite.
 Assumes all inputs synchronous to mclk_i and a free running clock.
*/
// The AXI4-Lite interface to the registers was decided locally.
//
// Functional notes
// - Restart at program address zero after reset.
// - Reload fuse-backed registers on every reset.
// - Record reset cause in readable flags.
// - Power-on detector holds and reasserts reset immediately.
// - Hold reset until initialization sequence completes.
// - Brown-out holds reset until supply recovers.
// - Filter short low pulses on reset pin.
// - Enabled pin holds reset while low.
// - Watchdog timeout causes system reset.
// - Soft trigger write starts reset immediately.
// - Unprotected soft reset write has no effect.
// - Debug reset only from debug link.
// - Supply resets also reset brown-out config, debug.
// - User resets spare brown-out config and debug.
// - Supply cause adds selected start-up delay.
// - CRC-on-boot lengthens initialization by scan.
// - Works in active and all sleep modes.
// - Flags clear on write one only.
// - Power-on clears all flags but power-on.
// - Brown-out keeps only power-on and brown-out flags.
// - Flag bits five down to zero by source.
// - Cause register at index zero, bits 7:6 zero.
// - Soft trigger bit always reads zero.
`timescale 1ns/100ps
module rsc_top
   import rsc_pkg::*;
#(
   parameter int          ADDR_W              = 8,
   parameter int          STARTUP_STEP_CYCLES = STARTUP_UNIT_CYCLES,
   parameter int          FILTER_CYCLES       = PIN_FILTER_CYCLES,
   parameter logic [7:0]  IO_REGISTER_KEY     = 8'h5A  // Arbitrary key value
) (
   input  wire logic              mclk_i,
   input  wire logic              reset_i,
   // Reset sources
   input  wire logic              power_on_undervolt_i,
   input  wire logic              brownout_enable_i,
   input  wire logic              brownout_low_i,
   input  wire logic              reset_pin_n_i,
   input  wire logic              reset_pin_function_select_i,
   input  wire logic              watchdog_timeout_i,
   input  wire logic              debug_link_reset_req_i,
   // Fuse settings and CRC scan done
   input  wire logic [2:0]        startup_delay_select_i,
   input  wire logic              crc_on_boot_select_i,
   input  wire logic              crc_scan_done_i,
   // Reset outputs
   output logic                   sys_reset_o,
   output logic                   brownout_cfg_reset_o,
   output logic                   debug_port_reset_o,
   output logic                   fuse_reload_o,
   output logic                   crc_scan_start_o,
   output logic                   pc_restart_o,
   output logic [15:0]            pc_start_addr_o,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i
);
   // Byte addresses of the registers
   localparam logic [ADDR_W-1:0] ADDR_CAUSE  = ADDR_W'({IDX_CAUSE, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_SOFT   = ADDR_W'({IDX_SOFT, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_UNLOCK = ADDR_W'({IDX_UNLOCK, 2'b00});
   localparam logic [15:0]       STEP        = 16'(STARTUP_STEP_CYCLES);

   rsc_state_t        state_q;         // Sequencer state
   logic [15:0]       cnt_q;           // Phase counter
   logic              supply_cause_q;  // Power supply caused this reset
   logic [FLAG_W-1:0] flags_q;         // Reset cause flags
   logic [2:0]        unlock_q;        // Unlock window cycles left
   logic              pc_restart_q;    // Restart pulse
   logic [15:0]       pc_addr_q;       // Restart address
   logic              aw_have_q;       // Write address held
   logic              w_have_q;        // Write data held
   logic [ADDR_W-1:0] aw_addr_q;       // Held write address
   logic [31:0]       w_data_q;        // Held write data
   logic              w_strb0_q;       // Low byte lane enabled
   logic              bvalid_q;        // Write response pending
   logic [1:0]        bresp_q;         // Write response code
   logic              rvalid_q;        // Read data pending
   logic [31:0]       rdata_q;         // Read data
   logic [1:0]        rresp_q;         // Read response code

   logic              bod_req;         // Brown-out request
   logic              supply_req;      // Power-on or brown-out
   logic              hold_req;        // Any level request
   logic              event_req;       // Any pulse request
   logic              wr_go;           // Write executes now
   logic              wr_cause;        // Write to cause flags
   logic              wr_soft;         // Write to soft reset
   logic              wr_unlock;       // Valid key write
   logic              soft_fire;       // Protected soft reset
   logic [15:0]       startup_delay;   // Selected start-up cycles
   logic              need_start;      // Start-up phase needed
   logic              to_run;          // Sequence ends this cycle
   logic [FLAG_W-1:0] set_flags;       // Flags raised this cycle

   rsc_pin_if pif ();

   // Pin filter instance
   rsc_pin_filter #(
      .FILTER_CYCLES (FILTER_CYCLES)
   ) u_pin_filter (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .pif     (pif)
   );

   assign pif.pin_n  = reset_pin_n_i;
   assign pif.enable = reset_pin_function_select_i;

   // Request merge; no clock gating so every sleep mode is covered
   assign bod_req    = brownout_enable_i & brownout_low_i;
   assign supply_req = power_on_undervolt_i | bod_req;
   assign hold_req   = supply_req | pif.request | debug_link_reset_req_i;
   assign event_req  = watchdog_timeout_i | soft_fire;
   assign startup_delay = 16'(16'(startup_delay_select_i) * STEP);
   assign need_start = supply_cause_q && (startup_delay != 16'h0000);

   // End of the initialization sequence
   always_comb begin
      to_run = 1'b0;
      if (!hold_req && !event_req) begin
         case (state_q)
            ST_FUSE:  to_run = (cnt_q == 16'h0000) && !need_start && !crc_on_boot_select_i;
            ST_START: to_run = (cnt_q == 16'h0000) && !crc_on_boot_select_i;
            ST_CRC:   to_run = crc_scan_done_i;
            default:  to_run = 1'b0;
         endcase
      end
   end

   // Sequencer: hold, fuse reload, start-up delay, CRC scan
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_q <= ST_HOLD;
         cnt_q   <= 16'h0000;
      end else if (hold_req || event_req) begin
         state_q <= ST_HOLD;
         cnt_q   <= 16'h0000;
      end else begin
         case (state_q)
            // All requests gone, reload fuses
            ST_HOLD: begin
               state_q <= ST_FUSE;
               cnt_q   <= FUSE_LOAD_CYCLES - 16'h0001;
            end
            // Fuse reload phase
            ST_FUSE: begin
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else if (need_start) begin
                  state_q <= ST_START;
                  cnt_q   <= startup_delay - 16'h0001;
               end else if (crc_on_boot_select_i) begin
                  state_q <= ST_CRC;
               end else begin
                  state_q <= ST_RUN;
               end
            end
            // Start-up delay phase
            ST_START: begin
               if (cnt_q != 16'h0000) begin
                  cnt_q <= cnt_q - 16'h0001;
               end else if (crc_on_boot_select_i) begin
                  state_q <= ST_CRC;
               end else begin
                  state_q <= ST_RUN;
               end
            end
            // Wait for the memory scan
            ST_CRC: begin
               if (crc_scan_done_i) begin
                  state_q <= ST_RUN;
               end
            end
            // Running
            ST_RUN: begin
               state_q <= ST_RUN;
            end
            default: begin
               state_q <= ST_HOLD;
            end
         endcase
      end
   end

   // Remember a supply cause until the sequence ends
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         supply_cause_q <= 1'b1;
      end else if (supply_req) begin
         supply_cause_q <= 1'b1;
      end else if (to_run) begin
         supply_cause_q <= 1'b0;
      end
   end

   // Restart pulse with address zero
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pc_restart_q <= 1'b0;
         pc_addr_q    <= PC_RESET_ADDR;
      end else begin
         pc_restart_q <= to_run;
         pc_addr_q    <= PC_RESET_ADDR;
      end
   end

   // Reset outputs per logic domain
   assign sys_reset_o          = hold_req | (state_q != ST_RUN);
   assign brownout_cfg_reset_o = supply_req | (supply_cause_q & (state_q != ST_RUN));
   assign debug_port_reset_o   = supply_req | (supply_cause_q & (state_q != ST_RUN));
   assign fuse_reload_o        = (state_q == ST_FUSE);
   assign crc_scan_start_o     = (state_q == ST_CRC);
   assign pc_restart_o         = pc_restart_q;
   assign pc_start_addr_o      = pc_addr_q;

   // Flags raised by each source; debug flag only from the link
   always_comb begin
      set_flags            = '0;
      set_flags[FLAG_POR]  = power_on_undervolt_i;
      set_flags[FLAG_BOD]  = bod_req;
      set_flags[FLAG_PIN]  = pif.request;
      set_flags[FLAG_WDT]  = watchdog_timeout_i;
      set_flags[FLAG_SOFT] = soft_fire;
      set_flags[FLAG_DBG]  = debug_link_reset_req_i;
   end

   // Cause flags: supply resets clear, sets win over clears
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         flags_q <= FLAGS_RESET;
      end else if (power_on_undervolt_i) begin
         flags_q <= FLAGS_POR_ONLY;
      end else if (bod_req) begin
         flags_q <= (flags_q & FLAGS_POR_ONLY) | set_flags;
      end else if (wr_cause) begin
         flags_q <= (flags_q & ~w_data_q[FLAG_W-1:0]) | set_flags;
      end else begin
         flags_q <= flags_q | set_flags;
      end
   end

   // Write decode
   assign wr_go     = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_cause  = wr_go & w_strb0_q & (aw_addr_q == ADDR_CAUSE);
   assign wr_soft   = wr_go & w_strb0_q & (aw_addr_q == ADDR_SOFT);
   assign wr_unlock = wr_go & w_strb0_q & (aw_addr_q == ADDR_UNLOCK) & (w_data_q[7:0] == IO_REGISTER_KEY);
   assign soft_fire = wr_soft & (unlock_q != 3'h0) & w_data_q[SOFT_TRIGGER_BIT];

   // Unlock window opened by the key, used by one write
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         unlock_q <= 3'h0;
      end else if (wr_unlock) begin
         unlock_q <= UNLOCK_CYCLES;
      end else if (wr_soft) begin
         unlock_q <= 3'h0;
      end else if (unlock_q != 3'h0) begin
         unlock_q <= unlock_q - 3'h1;
      end
   end

   // Write channels, taken in either order
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= 32'h00000000;
         w_strb0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end else if (wr_go) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_have_q  <= 1'b1;
            w_data_q  <= s_axi_wdata_i;
            w_strb0_q <= s_axi_wstrb_i[0];
         end else if (wr_go) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q  <= (aw_addr_q == ADDR_CAUSE || aw_addr_q == ADDR_SOFT ||
                      aw_addr_q == ADDR_UNLOCK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid_i && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q  <= RESP_OKAY;
         case (s_axi_araddr_i)
            ADDR_CAUSE:  rdata_q <= {26'h0000000, flags_q};
            ADDR_SOFT:   rdata_q <= 32'h00000000;
            ADDR_UNLOCK: rdata_q <= {31'h00000000, (unlock_q != 3'h0)};
            default: begin
               rdata_q <= 32'h00000000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready_i) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_awready_o = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready_o  = ~w_have_q & ~bvalid_q;
   assign s_axi_bvalid_o  = bvalid_q;
   assign s_axi_bresp_o   = bresp_q;
   assign s_axi_arready_o = ~rvalid_q;
   assign s_axi_rvalid_o  = rvalid_q;
   assign s_axi_rdata_o   = rdata_q;
   assign s_axi_rresp_o   = rresp_q;

   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   sequence s_released;
      state_q == ST_HOLD && !hold_req && !event_req;
   endsequence
   sequence s_pin_low2;
      !reset_pin_n_i ##1 !reset_pin_n_i;
   endsequence

   property p_restart_zero;
      pc_restart_o |-> pc_start_addr_o == 16'h0000 && !sys_reset_o && $past(sys_reset_o);
   endproperty
   a_restart_zero: assert property (p_restart_zero) else $error("restart not at zero");

   property p_fuse_reload;
      s_released ##1 !hold_req && !event_req |-> fuse_reload_o;
   endproperty
   a_fuse_reload: assert property (p_fuse_reload) else $error("no fuse reload");

   property p_por_hold;
      power_on_undervolt_i |-> sys_reset_o && brownout_cfg_reset_o && debug_port_reset_o;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("power-on not in reset");

   property p_release_after_seq;
      $fell(sys_reset_o) |-> pc_restart_o;
   endproperty
   a_release_after_seq: assert property (p_release_after_seq) else $error("early release");

   property p_bod_hold;
      bod_req |-> sys_reset_o ##1 state_q == ST_HOLD;
   endproperty
   a_bod_hold: assert property (p_bod_hold) else $error("brown-out not held");

   property p_pin_filter;
      $rose(pif.request) |-> $past(!reset_pin_n_i, 1) && $past(!reset_pin_n_i, 2);
   endproperty
   a_pin_filter: assert property (p_pin_filter) else $error("pin pulse not filtered");

   property p_pin_high;
      reset_pin_n_i |=> !pif.request;
   endproperty
   a_pin_high: assert property (p_pin_high) else $error("pin request after high");

   property p_soft_now;
      soft_fire |=> sys_reset_o && state_q == ST_HOLD && flags_q[FLAG_SOFT];
   endproperty
   a_soft_now: assert property (p_soft_now) else $error("soft reset late");

   property p_locked_write;
      wr_soft && unlock_q == 3'h0 && state_q == ST_RUN && !hold_req && !watchdog_timeout_i |=> state_q == ST_RUN;
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked write acted");

   property p_debug_flag;
      $rose(flags_q[FLAG_DBG]) |-> $past(debug_link_reset_req_i);
   endproperty
   a_debug_flag: assert property (p_debug_flag) else $error("debug flag without link");

   property p_por_flags;
      power_on_undervolt_i |=> flags_q == 6'h01;
   endproperty
   a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

   property p_bod_flags;
      bod_req && !power_on_undervolt_i |=> flags_q[FLAG_BOD] && flags_q[5:2] == 4'h0;
   endproperty
   a_bod_flags: assert property (p_bod_flags) else $error("brown-out flags wrong");
endmodule // rsc_top

// >>> src/rsc_pkg.sv
/*
 Package for the reset source controller: register map, flag layout,
 sequencer states and timing constants.
 Assumes a single 125 MHz system clock.
*/
package rsc_pkg;
   // Clock period of mclk_i
   localparam int CLK_PERIOD_NS = 8;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CAUSE  = 6'h00;
   localparam logic [5:0] IDX_SOFT   = 6'h01;
   localparam logic [5:0] IDX_UNLOCK = 6'h02;
   // Cause flag bit positions
   localparam int FLAG_POR  = 0;
   localparam int FLAG_BOD  = 1;
   localparam int FLAG_PIN  = 2;
   localparam int FLAG_WDT  = 3;
   localparam int FLAG_SOFT = 4;
   localparam int FLAG_DBG  = 5;
   localparam int FLAG_W    = 6;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [5:0] FLAGS_POR_ONLY = 6'h01;
   // Soft reset trigger bit position
   localparam int SOFT_TRIGGER_BIT = 0;
   // Restart address of the processor
   localparam logic [15:0] PC_RESET_ADDR = 16'h0000;
   // Cycles spent reloading fuses
   localparam logic [15:0] FUSE_LOAD_CYCLES = 16'h0008;
   // Unlock window after the key write, one cycle per instruction
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   // Least low time of the pin before it counts as a reset
   localparam int PIN_FILTER_NS = 100;
   localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // One step of the start-up delay select
   localparam int STARTUP_UNIT_NS = 1000;
   localparam int STARTUP_UNIT_CYCLES = (STARTUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sequencer states
   typedef enum logic [2:0] {
      ST_RUN   = 3'b000,
      ST_HOLD  = 3'b001,
      ST_FUSE  = 3'b010,
      ST_START = 3'b011,
      ST_CRC   = 3'b100
   } rsc_state_t;
endpackage

// >>> src/rsc_pin_if.sv
/*
 Carrier between the controller and its pin filter.
 Assumes the pin level is synchronous to mclk_i.
*/
`timescale 1ns/100ps
interface rsc_pin_if;
   logic pin_n;    // Raw pin level, low asks for reset
   logic enable;   // Pin function selected
   logic request;  // Filtered reset request
   modport filt (input pin_n, input enable, output request);
   modport ctrl (output pin_n, output enable, input request);
endinterface // rsc_pin_if

// >>> src/rsc_pin_filter.sv
/*
 Noise filter for the active-low reset pin.
 Assumes the pin is already synchronous to mclk_i.
*/
`timescale 1ns/100ps
module rsc_pin_filter
   import rsc_pkg::*;
#(
   parameter int FILTER_CYCLES = PIN_FILTER_CYCLES
) (
   input  wire logic mclk_i,
   input  wire logic reset_i,
   rsc_pin_if.filt   pif
);
   localparam int CW = $clog2(FILTER_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(FILTER_CYCLES - 1);

   logic [CW-1:0] low_cnt_q;  // Consecutive low samples
   logic          request_q;  // Filtered request

   // Count low samples, drop at once on high
   always_ff @(posedge mclk_i) begin
      if (reset_i || !pif.enable || pif.pin_n) begin
         low_cnt_q <= '0;
         request_q <= 1'b0;
      end else if (low_cnt_q == LAST) begin
         request_q <= 1'b1;
      end else begin
         low_cnt_q <= low_cnt_q + CW'(1);
      end
   end

   assign pif.request = request_q;
endmodule // rsc_pin_filter

// >>> dv/rsc_partner.sv
/*
 Memory CRC scanner stand-in for the reset source controller.
 Assumes scan start is a level held by the controller.
*/
`timescale 1ns/100ps
module rsc_partner (
   input  wire logic mclk_i,
   input  wire logic start_i,
   output logic      done_o
);
   logic [2:0] cnt_q;  // Scan cycles so far
   // Report the scan done six cycles after start, drop when start falls
   always_ff @(posedge mclk_i) begin
      if (!start_i) begin
         cnt_q  <= 3'h0;
         done_o <= 1'b0;
      end else if (cnt_q != 3'h5) begin
         cnt_q <= cnt_q + 3'h1;
      end else begin
         done_o <= 1'b1;
      end
   end
endmodule // rsc_partner

// >>> dv/rsc_top_test.sv
/*
 Bench for rsc_top: bus tasks, reset sources and cause flags.
 Assumes the partner model answers the CRC phase.
*/
`timescale 1ns/100ps
module rsc_top_test;
   logic        mclk_i = 1'b0;  // System clock
   logic        reset_i = 1'b1;  // Bench reset
   logic [5:0]  src_q = 6'h00;  // Requests by flag position
   logic        brownout_enable_i = 1'b1;
   logic        reset_pin_function_select_i = 1'b1;
   logic [2:0]  startup_delay_select_i = 3'h3;
   logic        crc_on_boot_select_i = 1'b1;
   logic        crc_scan_done_i;
   wire         power_on_undervolt_i = src_q[0];
   wire         brownout_low_i = src_q[1];
   wire         reset_pin_n_i = ~src_q[2];
   wire         watchdog_timeout_i = src_q[3];
   wire         debug_link_reset_req_i = src_q[5];
   logic        sys_reset_o, brownout_cfg_reset_o, debug_port_reset_o, fuse_reload_o;
   logic        crc_scan_start_o, pc_restart_o;
   logic [15:0] pc_start_addr_o;
   logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i = 4'hF;
   logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_arvalid_i = 1'b0;
   logic        s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   int          fails = 0, checks = 0, cyc = 0, rel = 0, pcs = 0;
   int          waited = 0;  // Edges spent in the last release wait
   logic        seen_fuse = 1'b0;  // Fuse phase observed
   logic [1:0]  r;  // Last response
   logic [31:0] d;  // Last read data

   rsc_top #(.STARTUP_STEP_CYCLES(2), .FILTER_CYCLES(2)) rsc_top_inst (.*);
   rsc_partner rsc_partner_inst (.mclk_i(mclk_i), .start_i(crc_scan_start_o), .done_o(crc_scan_done_i));

   always #4 mclk_i = ~mclk_i;
   // Cycle count, timeout and phase watchers
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (fuse_reload_o === 1'b1) seen_fuse <= 1'b1;
      if (pc_restart_o === 1'b1) pcs <= pcs + 1;
      if (crc_scan_start_o === 1'b1) chk("crc_hold", 1, sys_reset_o);
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= v;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      // Wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge mclk_i);
         if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      r = s_axi_bresp_o;
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      do begin
         @(posedge mclk_i);
         if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      r = s_axi_rresp_o;
      d = s_axi_rdata_o;
   endtask
   task automatic flags(input logic [31:0] e);
      rd(8'h00);
      chk("cause_flags", e, d);
   endtask
   // Wait for the sequence to end and the system to run
   task automatic rel_wait();
      waited = 0;
      while (waited < 500 && sys_reset_o !== 1'b0) begin
         @(posedge mclk_i);
         waited++;
      end
      chk("released", 0, sys_reset_o);
      rel++;
   endtask
   // Hold one source for four cycles, then release it
   task automatic fire(input int k);
      src_q[k] <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk("sys_reset", 1, sys_reset_o);
      chk("bod_cfg_reset", k < 2, brownout_cfg_reset_o);
      chk("dbg_reset", k < 2, debug_port_reset_o);
      src_q[k] <= 1'b0;
      @(posedge mclk_i);
      chk("init_hold", 1, sys_reset_o);
      rel_wait();
   endtask
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge mclk_i);
      reset_i <= 1'b0;
      rel_wait();
      chk("fuse_reload", 1, seen_fuse);
      chk("pc_addr", 16'h0000, pc_start_addr_o);
      wr(8'h00, 32'h3F);
      src_q[2] <= 1'b1;
      @(posedge mclk_i);
      src_q[2] <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chk("short_pin", 0, sys_reset_o);
      fire(2);
      flags(32'h04);
      fire(0);
      chk("seq_len_crc", rsc_pkg::FUSE_LOAD_CYCLES + 16'h000E, waited);
      flags(32'h01);
      fire(1);
      flags(32'h03);
      wr(8'h00, 32'h00);
      flags(32'h03);
      wr(8'h00, 32'h3F);
      flags(32'h00);
      fire(3);
      flags(32'h08);
      fire(5);
      flags(32'h28);
      wr(8'h00, 32'h3F);
      wr(8'h04, 32'h01);
      repeat (3) @(posedge mclk_i);
      chk("locked_soft", 0, sys_reset_o);
      wr(8'h08, 32'h5A);
      wr(8'h04, 32'h01);
      @(posedge mclk_i);
      chk("soft_fire", 1, sys_reset_o);
      rel_wait();
      flags(32'h10);
      rd(8'h04);
      chk("soft_read", 0, d);
      rd(8'h0C);
      chk("unmapped_resp", 2'h2, r);
      // Disabled pin and brown-out sources, then short sequences
      brownout_enable_i <= 1'b0;
      reset_pin_function_select_i <= 1'b0;
      crc_on_boot_select_i <= 1'b0;
      startup_delay_select_i <= 3'h0;
      src_q[2:1] <= 2'h3;
      repeat (4) @(posedge mclk_i);
      chk("disabled_src", 0, sys_reset_o);
      src_q[2:1] <= 2'h0;
      @(posedge mclk_i);
      fire(0);
      chk("seq_len_plain", rsc_pkg::FUSE_LOAD_CYCLES + 16'h0001, waited);
      startup_delay_select_i <= 3'h3;
      fire(0);
      chk("seq_len_start", rsc_pkg::FUSE_LOAD_CYCLES + 16'h0007, waited);
      flags(32'h01);
      chk("pc_restarts", rel, pcs);
      summarize();
   end
endmodule // rsc_top_test
